// file: include/dspdec_pkg.sv
// Purpose: constants and types for the instruction decoder block
// Assumes: 16-bit instruction words, AXI4-Lite register access
// Notes: opcode patterns are grouped by how many bits they fix
package dspdec_pkg;
	// register map, byte addresses
	localparam int AXI_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PC = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_FLAGS = 8'h0C;
	localparam logic [7:0] REG_INSTR = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_IDLE_BIT = 16;
	// control flag bits held by the decoder
	localparam int NUM_FLAGS = 7;
	localparam int FLG_CARRY = 0;
	localparam int FLG_INT_OFF = 1;
	localparam int FLG_TEST = 2;
	localparam int FLG_EXT = 3;
	localparam int FLG_PROG_BLK = 4;
	localparam int FLG_OVF_MODE = 5;
	localparam int FLG_SIGN_EXT = 6;
	// full opcodes
	localparam logic [15:0] OPC_POP_LOW = 16'hBE32;
	localparam logic [15:0] OPC_PUSH_LOW = 16'hBE3C;
	localparam logic [15:0] OPC_ACC_MINUS_PROD = 16'hBE05;
	localparam logic [15:0] OPC_XOR_LONG16 = 16'hBE83;
	// twelve-bit prefixes
	localparam logic [11:0] PFX_SET_BIT = 12'hBE4;
	localparam logic [11:0] PFX_SUB_LONG = 12'hBFA;
	localparam logic [11:0] PFX_XOR_LONG = 12'hBFD;
	// shorter prefixes
	localparam logic [5:0] PFX_COND_RET = 6'h3B;
	localparam logic [3:0] NIB_STORE_ACC = 4'h9;
	// upper bytes
	localparam logic [7:0] UB_POP_MEM = 8'h8A;
	localparam logic [7:0] UB_PUSH_MEM = 8'h76;
	localparam logic [7:0] UB_REPEAT_IMM = 8'hBB;
	localparam logic [7:0] UB_REPEAT_MEM = 8'h0B;
	localparam logic [7:0] UB_AUX_MINUS = 8'h7C;
	localparam logic [7:0] UB_SQUARE = 8'h53;
	localparam logic [7:0] UB_SAVE_STATUS_ZERO = 8'h8E;
	localparam logic [7:0] UB_SAVE_STATUS_ONE = 8'h8F;
	localparam logic [7:0] UB_STORE_LONG = 8'hAE;
	localparam logic [7:0] UB_SUB_HIGH = 8'h65;
	localparam logic [7:0] UB_SUB_SHORT = 8'hBA;
	localparam logic [7:0] UB_SUB_BORROW = 8'h64;
	localparam logic [7:0] UB_SUB_UNSIGNED = 8'h66;
	localparam logic [7:0] UB_SUB_TSHIFT = 8'h67;
	localparam logic [7:0] UB_XOR_DIRECT = 8'h6C;
	localparam logic [7:0] UB_ZERO_LOAD_RND = 8'h68;
	// low nibble of the set-bit group
	localparam logic [3:0] SB_CARRY = 4'hF;
	localparam logic [3:0] SB_INT_OFF = 4'h1;
	localparam logic [3:0] SB_TEST = 4'hB;
	localparam logic [3:0] SB_EXT = 4'hD;
	localparam logic [3:0] SB_PROG_BLK = 4'h5;
	localparam logic [3:0] SB_OVF_MODE = 4'h3;
	localparam logic [3:0] SB_SIGN_EXT = 4'h7;
	// field positions
	localparam int F_IND_BIT = 7;
	localparam int F_OFF_MSB = 6;
	localparam int F_AUX_MSB = 2;
	localparam int F_IMM_MSB = 7;
	localparam int F_HALF_BIT = 11;
	localparam int F_SHF3_MSB = 10;
	localparam int F_SHF3_LSB = 8;
	localparam int F_SHF4_MSB = 3;
	// cycle counts
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_TWO = 3'h2;
	localparam logic [2:0] CYC_RET_TAKEN = 3'h4;
	localparam logic [2:0] CYC_RET_SKIP = 3'h2;

	typedef enum logic [2:0] {
		S_IDLE, S_FETCH, S_OPWAIT, S_CONSTREQ, S_CONSTWAIT, S_EXEC
	} dspdec_state_type;

	typedef enum logic [4:0] {
		OP_NONE, OP_POP_LOW, OP_POP_TO_MEMORY, OP_PUSH_FROM_MEMORY,
		OP_PUSH_LOW, OP_CONDITIONAL_RETURN, OP_ACC_MINUS_PRODUCT,
		OP_REPEAT_IMM, OP_REPEAT_MEM, OP_STORE_ACC_HIGH_SHIFTED,
		OP_STORE_ACC_LOW_SHIFTED, OP_AUX_REG_MINUS_SHORT,
		OP_SET_CONTROL_BIT, OP_SQUARE_THEN_DEDUCT, OP_SAVE_STATUS_ZERO,
		OP_SAVE_STATUS_ONE, OP_STORE_LONG_CONSTANT, OP_SUB_LONG_SHIFTED,
		OP_ACC_MINUS_HIGH, OP_ACC_MINUS_SHORT, OP_ACC_MINUS_WITH_BORROW,
		OP_ACC_MINUS_UNSIGNED_LOW, OP_ACC_MINUS_TSHIFTED, OP_XOR_DIRECT,
		OP_XOR_LONG_SHIFTED, OP_XOR_LONG_SHIFT16,
		OP_CLEAR_LOW_LOAD_HIGH_ROUNDED, OP_UNKNOWN
	} dspdec_op_type;

	typedef struct packed {
		dspdec_op_type kind;
		logic addr_form;
		logic two_word;
		logic [2:0] cycles;
	} dspdec_dec_type;
endpackage

// file: logic/dspdec_core.sv
// Purpose: fetch and decode of the stack-to-zero opcode range
// Assumes: program memory answers a read one clock after the request
// Notes: registers over AXI4-Lite, one outstanding read and write
`timescale 1ns/1ps
module dspdec_core
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// axi4-lite write channels
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [dspdec_pkg::AXI_AW-1:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// axi4-lite read channels
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [dspdec_pkg::AXI_AW-1:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	// program memory
	output logic PM_RD,
	output logic [15:0] PM_ADDR,
	input wire logic [15:0] PM_DATA,
	// datapath condition for returns
	input wire logic COND_TRUE,
	// decoded instruction
	output logic OP_VALID,
	output dspdec_pkg::dspdec_op_type OP_KIND,
	output logic OP_INDIRECT,
	output logic [6:0] OP_OFFSET,
	output logic [2:0] OP_AUX_SEL,
	output logic [7:0] OP_IMM8,
	output logic [3:0] OP_SHIFT,
	output logic [15:0] OP_CONST,
	output logic [2:0] OP_CYCLES,
	// external flag pin
	output logic EXT_FLAG_PIN
);

	typedef struct packed {
		dspdec_pkg::dspdec_state_type state;
		logic run;
		logic [15:0] pc;
		logic [15:0] instr;
		logic [15:0] konst;
		logic op_valid;
		dspdec_pkg::dspdec_op_type kind;
		logic indirect;
		logic [6:0] offset;
		logic [2:0] aux_sel;
		logic [7:0] imm8;
		logic [3:0] shift;
		logic [2:0] cycles;
		logic [2:0] wait_cnt;
		logic [dspdec_pkg::NUM_FLAGS-1:0] flags;
		logic pm_rd;
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [dspdec_pkg::AXI_AW-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dspdec_core_type;

	dspdec_core_type st_q;
	dspdec_core_type st_d;

	// flag bits raised by one set-bit low nibble; zero means illegal
	function automatic logic [dspdec_pkg::NUM_FLAGS-1:0] set_mask
	(
		input logic [3:0] nib
	);
		logic [dspdec_pkg::NUM_FLAGS-1:0] m;
		m = '0;
		case (nib)
			dspdec_pkg::SB_CARRY: m[dspdec_pkg::FLG_CARRY] = 1'b1;
			dspdec_pkg::SB_INT_OFF: m[dspdec_pkg::FLG_INT_OFF] = 1'b1;
			dspdec_pkg::SB_TEST: m[dspdec_pkg::FLG_TEST] = 1'b1;
			dspdec_pkg::SB_EXT: m[dspdec_pkg::FLG_EXT] = 1'b1;
			dspdec_pkg::SB_PROG_BLK: m[dspdec_pkg::FLG_PROG_BLK] = 1'b1;
			dspdec_pkg::SB_OVF_MODE: m[dspdec_pkg::FLG_OVF_MODE] = 1'b1;
			dspdec_pkg::SB_SIGN_EXT: m[dspdec_pkg::FLG_SIGN_EXT] = 1'b1;
			default: m = '0;
		endcase
		return m;
	endfunction

	// byte-lane merge of a register write
	function automatic logic [31:0] lane_merge
	(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] strb
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// classify one instruction word; cond picks the return's length
	function automatic dspdec_pkg::dspdec_dec_type decode_op
	(
		input logic [15:0] w,
		input logic cond
	);
		dspdec_pkg::dspdec_dec_type r;
		r.kind = dspdec_pkg::OP_UNKNOWN;
		r.addr_form = 1'b0;
		r.two_word = 1'b0;
		r.cycles = dspdec_pkg::CYC_ONE;
		if (w == dspdec_pkg::OPC_POP_LOW)
			r.kind = dspdec_pkg::OP_POP_LOW;
		else if (w == dspdec_pkg::OPC_PUSH_LOW)
			r.kind = dspdec_pkg::OP_PUSH_LOW;
		else if (w == dspdec_pkg::OPC_ACC_MINUS_PROD)
			r.kind = dspdec_pkg::OP_ACC_MINUS_PRODUCT;
		else if (w == dspdec_pkg::OPC_XOR_LONG16)
		begin
			r.kind = dspdec_pkg::OP_XOR_LONG_SHIFT16;
			r.two_word = 1'b1;
			r.cycles = dspdec_pkg::CYC_TWO;
		end
		else if (w[15:4] == dspdec_pkg::PFX_SET_BIT)
		begin
			// unlisted nibbles stay unknown rather than touch a flag
			if (set_mask(w[3:0]) != '0)
				r.kind = dspdec_pkg::OP_SET_CONTROL_BIT;
		end
		else if (w[15:4] == dspdec_pkg::PFX_SUB_LONG)
		begin
			r.kind = dspdec_pkg::OP_SUB_LONG_SHIFTED;
			r.two_word = 1'b1;
			r.cycles = dspdec_pkg::CYC_TWO;
		end
		else if (w[15:4] == dspdec_pkg::PFX_XOR_LONG)
		begin
			r.kind = dspdec_pkg::OP_XOR_LONG_SHIFTED;
			r.two_word = 1'b1;
			r.cycles = dspdec_pkg::CYC_TWO;
		end
		else if (w[15:10] == dspdec_pkg::PFX_COND_RET)
		begin
			r.kind = dspdec_pkg::OP_CONDITIONAL_RETURN;
			r.cycles = cond ? dspdec_pkg::CYC_RET_TAKEN :
				dspdec_pkg::CYC_RET_SKIP;
		end
		else if (w[15:12] == dspdec_pkg::NIB_STORE_ACC)
		begin
			r.kind = w[dspdec_pkg::F_HALF_BIT] ?
				dspdec_pkg::OP_STORE_ACC_HIGH_SHIFTED :
				dspdec_pkg::OP_STORE_ACC_LOW_SHIFTED;
			r.addr_form = 1'b1;
		end
		else
		begin
			r.addr_form = 1'b1;
			case (w[15:8])
				dspdec_pkg::UB_POP_MEM: r.kind = dspdec_pkg::OP_POP_TO_MEMORY;
				dspdec_pkg::UB_PUSH_MEM:
					r.kind = dspdec_pkg::OP_PUSH_FROM_MEMORY;
				dspdec_pkg::UB_REPEAT_MEM: r.kind = dspdec_pkg::OP_REPEAT_MEM;
				dspdec_pkg::UB_SQUARE:
					r.kind = dspdec_pkg::OP_SQUARE_THEN_DEDUCT;
				dspdec_pkg::UB_SAVE_STATUS_ZERO:
					r.kind = dspdec_pkg::OP_SAVE_STATUS_ZERO;
				dspdec_pkg::UB_SAVE_STATUS_ONE:
					r.kind = dspdec_pkg::OP_SAVE_STATUS_ONE;
				dspdec_pkg::UB_SUB_HIGH:
					r.kind = dspdec_pkg::OP_ACC_MINUS_HIGH;
				dspdec_pkg::UB_SUB_BORROW:
					r.kind = dspdec_pkg::OP_ACC_MINUS_WITH_BORROW;
				dspdec_pkg::UB_SUB_UNSIGNED:
					r.kind = dspdec_pkg::OP_ACC_MINUS_UNSIGNED_LOW;
				dspdec_pkg::UB_SUB_TSHIFT:
					r.kind = dspdec_pkg::OP_ACC_MINUS_TSHIFTED;
				dspdec_pkg::UB_XOR_DIRECT: r.kind = dspdec_pkg::OP_XOR_DIRECT;
				dspdec_pkg::UB_ZERO_LOAD_RND:
					r.kind = dspdec_pkg::OP_CLEAR_LOW_LOAD_HIGH_ROUNDED;
				dspdec_pkg::UB_STORE_LONG:
				begin
					r.kind = dspdec_pkg::OP_STORE_LONG_CONSTANT;
					r.two_word = 1'b1;
					r.cycles = dspdec_pkg::CYC_TWO;
				end
				// immediate forms carry no address field
				dspdec_pkg::UB_REPEAT_IMM:
				begin
					r.kind = dspdec_pkg::OP_REPEAT_IMM;
					r.addr_form = 1'b0;
				end
				dspdec_pkg::UB_AUX_MINUS:
				begin
					r.kind = dspdec_pkg::OP_AUX_REG_MINUS_SHORT;
					r.addr_form = 1'b0;
				end
				dspdec_pkg::UB_SUB_SHORT:
				begin
					r.kind = dspdec_pkg::OP_ACC_MINUS_SHORT;
					r.addr_form = 1'b0;
				end
				default: r.addr_form = 1'b0;
			endcase
		end
		return r;
	endfunction

	// next state of the whole block
	always_comb
	begin
		dspdec_pkg::dspdec_dec_type dec;
		logic [dspdec_pkg::NUM_FLAGS-1:0] fset;
		logic [dspdec_pkg::NUM_FLAGS-1:0] fclr;
		logic [31:0] wv;
		logic done;
		logic [2:0] cyc;
		dec = decode_op(PM_DATA, COND_TRUE);
		fset = '0;
		fclr = '0;
		wv = '0;
		done = 1'b0;
		cyc = st_q.cycles;
		st_d = st_q;
		st_d.op_valid = 1'b0;
		st_d.pm_rd = 1'b0;

		// write path: address and data taken in either order
		if (AWVALID && st_q.awready)
		begin
			st_d.aw_got = 1'b1;
			st_d.waddr = AWADDR;
		end
		if (WVALID && st_q.wready)
		begin
			st_d.w_got = 1'b1;
			st_d.wdata = WDATA;
			st_d.wstrb = WSTRB;
		end
		if (st_q.bvalid && BREADY)
			st_d.bvalid = 1'b0;
		if (st_q.aw_got && st_q.w_got && !st_q.bvalid)
		begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = dspdec_pkg::RESP_OKAY;
			case (st_q.waddr)
				dspdec_pkg::REG_CTRL:
				begin
					wv = lane_merge({31'h0, st_q.run}, st_q.wdata, st_q.wstrb);
					st_d.run = wv[dspdec_pkg::CTRL_RUN_BIT];
				end
				// pc loads only while stopped, so a fetch never tears
				dspdec_pkg::REG_PC:
				begin
					wv = lane_merge({16'h0, st_q.pc}, st_q.wdata, st_q.wstrb);
					if (st_q.state == dspdec_pkg::S_IDLE)
						st_d.pc = wv[15:0];
				end
				dspdec_pkg::REG_FLAGS:
				begin
					wv = lane_merge('0, st_q.wdata, st_q.wstrb);
					fclr = wv[dspdec_pkg::NUM_FLAGS-1:0];
				end
				dspdec_pkg::REG_STATUS, dspdec_pkg::REG_INSTR: ;
				default: st_d.bresp = dspdec_pkg::RESP_SLVERR;
			endcase
		end
		st_d.awready = !st_d.aw_got && !st_d.bvalid;
		st_d.wready = !st_d.w_got && !st_d.bvalid;

		// read path: one read answered the cycle after its address
		if (st_q.rvalid && RREADY)
			st_d.rvalid = 1'b0;
		if (ARVALID && st_q.arready)
		begin
			st_d.rvalid = 1'b1;
			st_d.rresp = dspdec_pkg::RESP_OKAY;
			st_d.rdata = '0;
			case (ARADDR)
				dspdec_pkg::REG_CTRL: st_d.rdata[dspdec_pkg::CTRL_RUN_BIT] = st_q.run;
				dspdec_pkg::REG_PC: st_d.rdata[15:0] = st_q.pc;
				dspdec_pkg::REG_STATUS:
				begin
					st_d.rdata[4:0] = st_q.kind;
					st_d.rdata[10:8] = st_q.cycles;
					st_d.rdata[dspdec_pkg::STAT_IDLE_BIT] =
						(st_q.state == dspdec_pkg::S_IDLE);
				end
				dspdec_pkg::REG_FLAGS:
					st_d.rdata[dspdec_pkg::NUM_FLAGS-1:0] = st_q.flags;
				dspdec_pkg::REG_INSTR: st_d.rdata = {st_q.konst, st_q.instr};
				default: st_d.rresp = dspdec_pkg::RESP_SLVERR;
			endcase
		end
		st_d.arready = !st_d.rvalid;

		// fetch and decode sequence
		unique case (st_q.state)
			dspdec_pkg::S_IDLE:
			begin
				if (st_q.run)
				begin
					st_d.state = dspdec_pkg::S_FETCH;
					st_d.pm_rd = 1'b1;
				end
			end
			dspdec_pkg::S_FETCH: st_d.state = dspdec_pkg::S_OPWAIT;
			dspdec_pkg::S_OPWAIT:
			begin
				st_d.instr = PM_DATA;
				st_d.kind = dec.kind;
				st_d.cycles = dec.cycles;
				cyc = dec.cycles;
				st_d.indirect = dec.addr_form && PM_DATA[dspdec_pkg::F_IND_BIT];
				st_d.offset = PM_DATA[dspdec_pkg::F_OFF_MSB:0];
				st_d.aux_sel = PM_DATA[dspdec_pkg::F_AUX_MSB:0];
				st_d.imm8 = PM_DATA[dspdec_pkg::F_IMM_MSB:0];
				st_d.shift = '0;
				if (PM_DATA[15:12] == dspdec_pkg::NIB_STORE_ACC)
					st_d.shift = {1'b0, PM_DATA[dspdec_pkg::F_SHF3_MSB:
						dspdec_pkg::F_SHF3_LSB]};
				else if (dec.two_word)
					st_d.shift = PM_DATA[dspdec_pkg::F_SHF4_MSB:0];
				if (dec.kind == dspdec_pkg::OP_SET_CONTROL_BIT)
					fset = set_mask(PM_DATA[3:0]);
				st_d.pc = st_q.pc + 16'h0001;
				if (dec.two_word)
				begin
					st_d.state = dspdec_pkg::S_CONSTREQ;
					st_d.pm_rd = 1'b1;
				end
				else
				begin
					st_d.op_valid = 1'b1;
					done = 1'b1;
				end
			end
			dspdec_pkg::S_CONSTREQ: st_d.state = dspdec_pkg::S_CONSTWAIT;
			dspdec_pkg::S_CONSTWAIT:
			begin
				st_d.konst = PM_DATA;
				st_d.pc = st_q.pc + 16'h0001;
				st_d.op_valid = 1'b1;
				done = 1'b1;
			end
			dspdec_pkg::S_EXEC:
			begin
				if (st_q.wait_cnt == '0)
				begin
					cyc = dspdec_pkg::CYC_ONE;
					done = 1'b1;
				end
				else
					st_d.wait_cnt = 3'(st_q.wait_cnt - 3'h1);
			end
			default: st_d.state = dspdec_pkg::S_IDLE;
		endcase

		// hold extra cycles, then fetch again or stop when run is off
		if (done)
		begin
			if (cyc > dspdec_pkg::CYC_ONE)
			begin
				st_d.state = dspdec_pkg::S_EXEC;
				st_d.wait_cnt = 3'(cyc - 3'h2);
			end
			else if (st_q.run)
			begin
				st_d.state = dspdec_pkg::S_FETCH;
				st_d.pm_rd = 1'b1;
			end
			else
				st_d.state = dspdec_pkg::S_IDLE;
		end

		// a set from decode wins over a software clear
		st_d.flags = (st_q.flags & ~fclr) | fset;
	end

	// state register; all fields start at zero
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// outputs straight from the state register
	assign AWREADY = st_q.awready;
	assign WREADY = st_q.wready;
	assign BVALID = st_q.bvalid;
	assign BRESP = st_q.bresp;
	assign ARREADY = st_q.arready;
	assign RVALID = st_q.rvalid;
	assign RDATA = st_q.rdata;
	assign RRESP = st_q.rresp;
	assign PM_RD = st_q.pm_rd;
	assign PM_ADDR = st_q.pc;
	assign OP_VALID = st_q.op_valid;
	assign OP_KIND = st_q.kind;
	assign OP_INDIRECT = st_q.indirect;
	assign OP_OFFSET = st_q.offset;
	assign OP_AUX_SEL = st_q.aux_sel;
	assign OP_IMM8 = st_q.imm8;
	assign OP_SHIFT = st_q.shift;
	assign OP_CONST = st_q.konst;
	assign OP_CYCLES = st_q.cycles;
	assign EXT_FLAG_PIN = st_q.flags[dspdec_pkg::FLG_EXT];

	// checks on decode results and their timing
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);

	logic at_dec;
	assign at_dec = (st_q.state == dspdec_pkg::S_OPWAIT);

	property p_pop_low;
		at_dec && PM_DATA == dspdec_pkg::OPC_POP_LOW |=> OP_VALID &&
			OP_KIND == dspdec_pkg::OP_POP_LOW &&
			OP_CYCLES == dspdec_pkg::CYC_ONE;
	endproperty
	a_pop_low: assert property (p_pop_low)
		else $error("pop to low half misdecoded");

	property p_ret_taken;
		at_dec && PM_DATA[15:10] == dspdec_pkg::PFX_COND_RET && COND_TRUE
			|=> OP_CYCLES == dspdec_pkg::CYC_RET_TAKEN ##0
			(st_q.state == dspdec_pkg::S_EXEC)[*3];
	endproperty
	a_ret_taken: assert property (p_ret_taken)
		else $error("taken return not four cycles");

	property p_ret_skip;
		at_dec && PM_DATA[15:10] == dspdec_pkg::PFX_COND_RET && !COND_TRUE
			|=> OP_CYCLES == dspdec_pkg::CYC_RET_SKIP ##1
			st_q.state != dspdec_pkg::S_EXEC;
	endproperty
	a_ret_skip: assert property (p_ret_skip)
		else $error("skipped return not two cycles");

	property p_repeat_imm;
		at_dec && PM_DATA[15:8] == dspdec_pkg::UB_REPEAT_IMM |=>
			OP_KIND == dspdec_pkg::OP_REPEAT_IMM &&
			OP_IMM8 == $past(PM_DATA[7:0]);
	endproperty
	a_repeat_imm: assert property (p_repeat_imm)
		else $error("repeat count not taken from immediate");

	property p_store_shift;
		at_dec && PM_DATA[15:12] == dspdec_pkg::NIB_STORE_ACC |=>
			OP_SHIFT[2:0] == $past(PM_DATA[10:8]) &&
			(OP_KIND == dspdec_pkg::OP_STORE_ACC_HIGH_SHIFTED) ==
			$past(PM_DATA[11]);
	endproperty
	a_store_shift: assert property (p_store_shift)
		else $error("store half or shift wrong");

	property p_ext_pin;
		at_dec && PM_DATA == {dspdec_pkg::PFX_SET_BIT, dspdec_pkg::SB_EXT}
			|=> EXT_FLAG_PIN && OP_VALID;
	endproperty
	a_ext_pin: assert property (p_ext_pin)
		else $error("external flag pin not raised");

	property p_store_long;
		at_dec && PM_DATA[15:8] == dspdec_pkg::UB_STORE_LONG |=> PM_RD &&
			!OP_VALID && PM_ADDR == 16'($past(PM_ADDR) + 16'h0001) ##2
			OP_VALID && OP_CONST == $past(PM_DATA) &&
			OP_KIND == dspdec_pkg::OP_STORE_LONG_CONSTANT;
	endproperty
	a_store_long: assert property (p_store_long)
		else $error("long constant not fetched");

	property p_const_skip;
		st_q.state == dspdec_pkg::S_CONSTWAIT |=>
			PM_ADDR == 16'($past(PM_ADDR) + 16'h0001);
	endproperty
	a_const_skip: assert property (p_const_skip)
		else $error("counter not past constant word");

	property p_indirect;
		at_dec && PM_DATA[15:8] == dspdec_pkg::UB_POP_MEM |=>
			OP_KIND == dspdec_pkg::OP_POP_TO_MEMORY &&
			OP_INDIRECT == $past(PM_DATA[7]) &&
			OP_OFFSET == $past(PM_DATA[6:0]);
	endproperty
	a_indirect: assert property (p_indirect)
		else $error("address mode bit misread");

	property p_sub_short;
		at_dec && PM_DATA[15:8] == dspdec_pkg::UB_SUB_SHORT |=>
			OP_KIND == dspdec_pkg::OP_ACC_MINUS_SHORT && !OP_INDIRECT &&
			OP_IMM8 == $past(PM_DATA[7:0]);
	endproperty
	a_sub_short: assert property (p_sub_short)
		else $error("short subtract misdecoded");
endmodule

// file: verif/dspdec_pm_model.sv
// Purpose: program memory seen by the decoder's fetch port
// Assumes: one read pulse, data registered for the next cycle
// Notes: between reads the data bus toggles, so stale words show
`timescale 1ns/1ps
module dspdec_pm_model
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// fetch port
	input wire logic pm_rd,
	input wire logic [15:0] pm_addr,
	output logic [15:0] pm_data
);
	logic [15:0] mem [0:63];

	// unloaded words decode as unknown, never as x
	initial
	begin
		foreach (mem[i])
			mem[i] = 16'hFFFF;
	end

	// word after the opcode is the constant of a long form
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			pm_data <= 16'hA5A5;
		else if (pm_rd)
			pm_data <= mem[pm_addr[5:0]];
		else
			pm_data <= ~pm_data;
	end
endmodule

// file: verif/dspdec_core_tb_top.sv
// Purpose: self-checking bench for the decoder
// Assumes: registers over axi4-lite, memory model on the fetch port
// Notes: decodes are checked in program order, so skips show up
`timescale 1ns/1ps
module dspdec_core_tb_top;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic cond = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, pm_rd, op_vld, op_ind, ext;
	logic [1:0] b_resp, r_resp;
	logic [31:0] r_data;
	logic [15:0] pm_addr, pm_data, op_cst;
	logic [6:0] op_off;
	logic [2:0] op_aux, op_cyc;
	logic [7:0] op_imm;
	logic [3:0] op_shf;
	dspdec_pkg::dspdec_op_type op_kind;
	logic [15:0] tw [0:39];
	logic [15:0] tc [0:39];
	dspdec_pkg::dspdec_op_type tk [0:39];
	int nt = 0, na = 0, failures = 0, n_compared = 0, cyc = 0;

	dspdec_core u_dspdec_core (.CLK_SYS(clk_sys), .RST_B(rst_b),
		.AWVALID(awv), .AWREADY(aw_rdy), .AWADDR(awa), .WVALID(wv),
		.WREADY(w_rdy), .WDATA(wd), .WSTRB(4'hF), .BVALID(b_vld),
		.BREADY(bre), .BRESP(b_resp), .ARVALID(arv), .ARREADY(ar_rdy),
		.ARADDR(ara), .RVALID(r_vld), .RREADY(rre), .RDATA(r_data),
		.RRESP(r_resp), .PM_RD(pm_rd), .PM_ADDR(pm_addr),
		.PM_DATA(pm_data), .COND_TRUE(cond), .OP_VALID(op_vld),
		.OP_KIND(op_kind), .OP_INDIRECT(op_ind), .OP_OFFSET(op_off),
		.OP_AUX_SEL(op_aux), .OP_IMM8(op_imm), .OP_SHIFT(op_shf),
		.OP_CONST(op_cst), .OP_CYCLES(op_cyc), .EXT_FLAG_PIN(ext));
	dspdec_pm_model u_dspdec_pm_model (.clk_sys(clk_sys), .rst_b(rst_b),
		.pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data));

	// clock and hang guard
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			failures++;
			end_of_test();
		end
	end

	task end_of_test();
		if (failures == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// write: both channels offered, each dropped when taken
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		bre <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (awv && aw_rdy)
				awv <= 1'b0;
			if (wv && w_rdy)
				wv <= 1'b0;
		end while (b_vld !== 1'b1);
		r = b_resp;
		bre <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		arv <= 1'b1;
		ara <= a;
		rre <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (arv && ar_rdy)
				arv <= 1'b0;
		end while (r_vld !== 1'b1);
		d = r_data;
		r = r_resp;
		rre <= 1'b0;
	endtask

	function automatic bit two(input dspdec_pkg::dspdec_op_type k);
		return k inside {dspdec_pkg::OP_STORE_LONG_CONSTANT,
			dspdec_pkg::OP_SUB_LONG_SHIFTED, dspdec_pkg::OP_XOR_LONG_SHIFTED,
			dspdec_pkg::OP_XOR_LONG_SHIFT16};
	endfunction

	// append one instruction to the table and to program memory
	task t(input logic [15:0] w, c, input dspdec_pkg::dspdec_op_type k);
		tw[nt] = w;
		tc[nt] = c;
		tk[nt] = k;
		nt++;
		u_dspdec_pm_model.mem[na] = w;
		na++;
		if (two(k))
		begin
			u_dspdec_pm_model.mem[na] = c;
			na++;
		end
	endtask

	// run the table from address zero, then stop and wait for idle
	task run(input logic cv);
		logic [1:0] r;
		logic [31:0] d;
		int j;
		cond <= cv;
		wr(dspdec_pkg::REG_PC, 32'h0, r);
		wr(dspdec_pkg::REG_CTRL, 32'h1, r);
		for (int i = 0; i < nt; i++)
		begin
			j = 0;
			do
			begin
				@(negedge clk_sys);
				j++;
			end while (op_vld !== 1'b1 && j < 60);
			chk("valid", 32'(op_vld), 32'h1);
			chk("kind", 32'(op_kind), 32'(tk[i]));
			chk("cycles", 32'(op_cyc), two(tk[i]) ? 2 :
				tk[i] == dspdec_pkg::OP_CONDITIONAL_RETURN ? (cv ? 4 : 2) : 1);
			chk("imm", 32'(op_imm), 32'(tw[i][7:0]));
			chk("offset", 32'(op_off), 32'(tw[i][6:0]));
			chk("aux", 32'(op_aux), 32'(tw[i][2:0]));
			if (i < 3)
				chk("indirect", 32'(op_ind), 32'(tw[i][7]));
			if (two(tk[i]))
				chk("const", 32'(op_cst), 32'(tc[i]));
		end
		wr(dspdec_pkg::REG_CTRL, 32'h0, r);
		j = 0;
		do
		begin
			rd(dspdec_pkg::REG_STATUS, d, r);
			j++;
		end while (d[16] !== 1'b1 && j < 20);
		chk("idle", 32'(d[16]), 32'h1);
	endtask

	task s_regs();
		logic [1:0] r;
		logic [31:0] d;
		rd(dspdec_pkg::REG_CTRL, d, r);
		chk("ctrl", d, 32'h0);
		rd(dspdec_pkg::REG_FLAGS, d, r);
		chk("flags", d, 32'h0);
		rd(8'h14, d, r);
		chk("rresp", 32'(r), 32'(dspdec_pkg::RESP_SLVERR));
		wr(8'h14, 32'h1, r);
		chk("bresp", 32'(r), 32'(dspdec_pkg::RESP_SLVERR));
	endtask

	task s_decode();
		logic [27:0] nibs;
		nibs = 28'hF1BD537;
		t(16'hBE32, 16'h0, dspdec_pkg::OP_POP_LOW);
		t(16'h8A85, 16'h0, dspdec_pkg::OP_POP_TO_MEMORY);
		t(16'h7612, 16'h0, dspdec_pkg::OP_PUSH_FROM_MEMORY);
		t(16'hBE3C, 16'h0, dspdec_pkg::OP_PUSH_LOW);
		t(16'hEF00, 16'h0, dspdec_pkg::OP_CONDITIONAL_RETURN);
		t(16'hBE05, 16'h0, dspdec_pkg::OP_ACC_MINUS_PRODUCT);
		t(16'hBB7F, 16'h0, dspdec_pkg::OP_REPEAT_IMM);
		t(16'h0B01, 16'h0, dspdec_pkg::OP_REPEAT_MEM);
		t(16'h9D05, 16'h0, dspdec_pkg::OP_STORE_ACC_HIGH_SHIFTED);
		t(16'h9205, 16'h0, dspdec_pkg::OP_STORE_ACC_LOW_SHIFTED);
		t(16'h7C10, 16'h0, dspdec_pkg::OP_AUX_REG_MINUS_SHORT);
		// one set-bit op per listed low nibble, top nibble first
		for (int n = 0; n < 7; n++)
		begin
			t({12'hBE4, nibs[27:24]}, 16'h0,
				dspdec_pkg::OP_SET_CONTROL_BIT);
			nibs = nibs << 4;
		end
		t(16'h5301, 16'h0, dspdec_pkg::OP_SQUARE_THEN_DEDUCT);
		t(16'h8E02, 16'h0, dspdec_pkg::OP_SAVE_STATUS_ZERO);
		t(16'h8F02, 16'h0, dspdec_pkg::OP_SAVE_STATUS_ONE);
		t(16'hAE03, 16'h1234, dspdec_pkg::OP_STORE_LONG_CONSTANT);
		t(16'hBFA3, 16'h5678, dspdec_pkg::OP_SUB_LONG_SHIFTED);
		t(16'h6501, 16'h0, dspdec_pkg::OP_ACC_MINUS_HIGH);
		t(16'hBA20, 16'h0, dspdec_pkg::OP_ACC_MINUS_SHORT);
		t(16'h6401, 16'h0, dspdec_pkg::OP_ACC_MINUS_WITH_BORROW);
		t(16'h6601, 16'h0, dspdec_pkg::OP_ACC_MINUS_UNSIGNED_LOW);
		t(16'h6701, 16'h0, dspdec_pkg::OP_ACC_MINUS_TSHIFTED);
		t(16'h6C01, 16'h0, dspdec_pkg::OP_XOR_DIRECT);
		t(16'hBFD2, 16'h9ABC, dspdec_pkg::OP_XOR_LONG_SHIFTED);
		t(16'hBE83, 16'hDEF0, dspdec_pkg::OP_XOR_LONG_SHIFT16);
		t(16'h6881, 16'h0, dspdec_pkg::OP_CLEAR_LOW_LOAD_HIGH_ROUNDED);
		t(16'hBE49, 16'h0, dspdec_pkg::OP_UNKNOWN);
		run(1'b1);
	endtask

	// every set-bit op ran once; flags clear by writing ones
	task s_flags();
		logic [1:0] r;
		logic [31:0] d;
		rd(dspdec_pkg::REG_FLAGS, d, r);
		chk("flags", d, 32'h7F);
		chk("pin", 32'(ext), 32'h1);
		wr(dspdec_pkg::REG_FLAGS, 32'h7F, r);
		rd(dspdec_pkg::REG_FLAGS, d, r);
		chk("flags", d, 32'h0);
		chk("pin", 32'(ext), 32'h0);
	endtask

	task s_ret_skip();
		nt = 0;
		na = 0;
		t(16'hEC21, 16'h0, dspdec_pkg::OP_CONDITIONAL_RETURN);
		t(16'hBE32, 16'h0, dspdec_pkg::OP_POP_LOW);
		run(1'b0);
	endtask

	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		s_regs();
		s_decode();
		s_flags();
		s_ret_skip();
		end_of_test();
	end
endmodule
